// ==== design/exec_unit_defines.vh ====
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_INSTR   8'h00
`define REG_STAT    8'h04
`define REG_ACC     8'h08
`define REG_FLAGS   8'h0C
`define REG_TPLO    8'h10
`define REG_TPHI    8'h14
`define REG_THIGH   8'h18
`define REG_PAGE    8'h1C
`define REG_MADDR   8'h20
`define REG_MDATA   8'h24

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define OP_LSB      0
`define OP_W        4
`define BIT_LSB     4
`define BIT_W       3
`define MADR_LSB    8
`define IMM_LSB     16

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_NOP      4'h0
`define OP_SWAP     4'h1
`define OP_SWAP_ACC 4'h2
`define OP_SKZ      4'h3
`define OP_SKZA     4'h4
`define OP_SKZBIT   4'h5
`define OP_TRD_PAIR 4'h6
`define OP_TRD_CUR  4'h7
`define OP_TRD_LAST 4'h8
`define OP_XORA     4'h9
`define OP_XOR_MEM  4'hA
`define OP_XORI     4'hB

// ----------------------------------------------------------------
// status bits, flag bits, reset values, bus answers
// ----------------------------------------------------------------
`define STAT_BUSY   0
`define STAT_SKIP   1
`define STAT_ILL    2
`define STAT_CYC    4
`define FLAG_Z      2
`define RST_BYTE    8'h00
`define RST_WORD    32'h0000_0000
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`define CYC_ONE     2'h1
`define CYC_TWO     2'h2

`endif

// ==== design/nibble_skip_xor_alu.v ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defines.vh"

module nibble_skip_xor_alu (
    input  wire [3:0] op,
    input  wire [2:0] bit_sel,
    input  wire [7:0] mem_val,
    input  wire [7:0] acc_val,
    input  wire [7:0] imm_val,
    output reg  [7:0] res,
    output reg        wr_mem,
    output reg        wr_acc,
    output reg        z_upd,
    output reg        skip,
    output reg        is_table,
    output reg        illegal
);

    wire [7:0] swapped;
    wire       mem_zero;

    assign swapped  = {mem_val[3:0], mem_val[7:4]};
    assign mem_zero = (mem_val == 8'h00);

    always @* begin
        res      = 8'h00;
        wr_mem   = 1'b0;
        wr_acc   = 1'b0;
        z_upd    = 1'b0;
        skip     = 1'b0;
        is_table = 1'b0;
        illegal  = 1'b0;
        case (op)
            `OP_NOP: begin
            end
            `OP_SWAP: begin
                res    = swapped;
                wr_mem = 1'b1;
            end
            `OP_SWAP_ACC: begin
                res    = swapped;
                wr_acc = 1'b1;
            end
            `OP_SKZ: begin
                skip = mem_zero;
            end
            `OP_SKZA: begin
                res    = mem_val;
                wr_acc = 1'b1;
                skip   = mem_zero;
            end
            `OP_SKZBIT: begin
                skip = ~mem_val[bit_sel];
            end
            `OP_TRD_PAIR, `OP_TRD_CUR, `OP_TRD_LAST: begin
                is_table = 1'b1;
            end
            `OP_XORA: begin
                res    = acc_val ^ mem_val;
                wr_acc = 1'b1;
                z_upd  = 1'b1;
            end
            `OP_XOR_MEM: begin
                res    = acc_val ^ mem_val;
                wr_mem = 1'b1;
                z_upd  = 1'b1;
            end
            `OP_XORI: begin
                res    = acc_val ^ imm_val;
                wr_acc = 1'b1;
                z_upd  = 1'b1;
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
    end

endmodule

`default_nettype wire

// ==== design/swap_skip_table_xor_unit.v ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defines.vh"

module swap_skip_table_xor_unit #(
    parameter DM_AW = 8,
    parameter PM_AW = 16
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             ce,
    input  wire [7:0]       s_axi_awaddr,
    input  wire [2:0]       s_axi_awprot,
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [7:0]       s_axi_araddr,
    input  wire [2:0]       s_axi_arprot,
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    output reg  [PM_AW-1:0] pm_addr,
    output reg              pm_rd,
    input  wire [15:0]      pm_rdata,
    output reg              busy,
    output reg              skip_cycle
);

    // ----------------------------------------------------------------
    // execution states
    // ----------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_EXEC  = 3'd1;
    localparam [2:0] S_DUMMY = 3'd2;
    localparam [2:0] S_TWAIT = 3'd3;
    localparam [2:0] S_TCAP  = 3'd4;
    localparam       PG_W    = PM_AW - 8;

    reg  [7:0]       dmem [0:(1<<DM_AW)-1];
    reg  [2:0]       state_q;
    reg  [23:0]      instr_q;
    reg  [7:0]       acc_q;
    reg  [7:0]       flags_q;
    reg  [7:0]       tplo_q;
    reg  [7:0]       tphi_q;
    reg  [7:0]       thigh_q;
    reg  [PG_W-1:0]  page_q;
    reg  [DM_AW-1:0] maddr_q;
    reg              skip_seen_q;
    reg              ill_q;
    reg  [1:0]       cyc_q;
    reg              aw_have_q;
    reg  [7:0]       aw_addr_q;
    reg              w_have_q;
    reg  [31:0]      w_data_q;
    reg  [3:0]       w_strb_q;

    wire [3:0]       op;
    wire [2:0]       bit_sel;
    wire [DM_AW-1:0] op_addr;
    wire [7:0]       imm_val;
    wire [7:0]       mem_val;
    wire [7:0]       alu_res;
    wire             alu_wr_mem;
    wire             alu_wr_acc;
    wire             alu_z_upd;
    wire             alu_skip;
    wire             alu_table;
    wire             alu_ill;
    wire             wr_fire;
    wire [31:0]      wmask;
    wire [31:0]      wval;
    wire             exec_now;

    reg              dm_we;
    reg  [DM_AW-1:0] dm_wa;
    reg  [7:0]       dm_wd;
    reg              wr_ok;
    reg  [31:0]      rd_val;
    reg              rd_ok;
    reg  [PM_AW-1:0] tbl_addr;

    assign op       = instr_q[`OP_LSB +: `OP_W];
    assign bit_sel  = instr_q[`BIT_LSB +: `BIT_W];
    assign op_addr  = instr_q[`MADR_LSB +: DM_AW];
    assign imm_val  = instr_q[`IMM_LSB +: 8];
    assign mem_val  = dmem[op_addr];
    assign exec_now = (state_q == S_EXEC);

    // ----------------------------------------------------------------
    // operation datapath
    // ----------------------------------------------------------------
    nibble_skip_xor_alu alu (
        .op       (op),
        .bit_sel  (bit_sel),
        .mem_val  (mem_val),
        .acc_val  (acc_q),
        .imm_val  (imm_val),
        .res      (alu_res),
        .wr_mem   (alu_wr_mem),
        .wr_acc   (alu_wr_acc),
        .z_upd    (alu_z_upd),
        .skip     (alu_skip),
        .is_table (alu_table),
        .illegal  (alu_ill)
    );

    // ----------------------------------------------------------------
    // program memory address for the three table reads
    // ----------------------------------------------------------------
    always @* begin
        case (op)
            `OP_TRD_PAIR: tbl_addr = {tphi_q[PG_W-1:0], tplo_q};
            `OP_TRD_CUR:  tbl_addr = {page_q, tplo_q};
            `OP_TRD_LAST: tbl_addr = {{PG_W{1'b1}}, tplo_q};
            default:      tbl_addr = {PM_AW{1'b0}};
        endcase
    end

    // ----------------------------------------------------------------
    // bus write decode
    // ----------------------------------------------------------------
    assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wval    = w_data_q & wmask;

    // writes that would race the running instruction are refused
    always @* begin
        case (aw_addr_q)
            `REG_INSTR, `REG_ACC, `REG_FLAGS, `REG_TPLO, `REG_TPHI,
            `REG_THIGH, `REG_PAGE, `REG_MADDR, `REG_MDATA:
                wr_ok = ~busy;
            default:
                wr_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // data memory write port, one writer at a time
    // ----------------------------------------------------------------
    always @* begin
        dm_we = 1'b0;
        dm_wa = op_addr;
        dm_wd = alu_res;
        if (exec_now && alu_wr_mem) begin
            dm_we = 1'b1;
        end else if (state_q == S_TCAP) begin
            dm_we = 1'b1;
            dm_wd = pm_rdata[7:0];
        end else if (wr_fire && wr_ok && aw_addr_q == `REG_MDATA
                     && w_strb_q[0]) begin
            dm_we = 1'b1;
            dm_wa = maddr_q;
            dm_wd = w_data_q[7:0];
        end
    end

    always @(posedge aclk) begin
        if (ce && dm_we) begin
            dmem[dm_wa] <= dm_wd;
        end
    end

    // ----------------------------------------------------------------
    // bus read decode
    // ----------------------------------------------------------------
    always @* begin
        rd_val = `RST_WORD;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `REG_INSTR: rd_val[23:0] = instr_q;
            `REG_STAT: begin
                rd_val[`STAT_BUSY]     = busy;
                rd_val[`STAT_SKIP]     = skip_seen_q;
                rd_val[`STAT_ILL]      = ill_q;
                rd_val[`STAT_CYC +: 2] = cyc_q;
            end
            `REG_ACC:   rd_val[7:0] = acc_q;
            `REG_FLAGS: rd_val[7:0] = flags_q;
            `REG_TPLO:  rd_val[7:0] = tplo_q;
            `REG_TPHI:  rd_val[7:0] = tphi_q;
            `REG_THIGH: rd_val[7:0] = thigh_q;
            `REG_PAGE:  rd_val[PG_W-1:0] = page_q;
            `REG_MADDR: rd_val[DM_AW-1:0] = maddr_q;
            `REG_MDATA: rd_val[7:0] = dmem[maddr_q];
            default:    rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // bus handshakes: address and data may arrive in either order
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= `RST_WORD;
            aw_have_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_have_q      <= 1'b0;
            w_data_q      <= `RST_WORD;
            w_strb_q      <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register file and instruction sequencer
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= S_IDLE;
            instr_q     <= 24'h00_0000;
            acc_q       <= `RST_BYTE;
            flags_q     <= `RST_BYTE;
            tplo_q      <= `RST_BYTE;
            tphi_q      <= `RST_BYTE;
            thigh_q     <= `RST_BYTE;
            page_q      <= {PG_W{1'b0}};
            maddr_q     <= {DM_AW{1'b0}};
            skip_seen_q <= 1'b0;
            ill_q       <= 1'b0;
            cyc_q       <= 2'h0;
            pm_addr     <= {PM_AW{1'b0}};
            pm_rd       <= 1'b0;
            busy        <= 1'b0;
            skip_cycle  <= 1'b0;
        end else if (ce) begin
            if (wr_fire && wr_ok) begin
                case (aw_addr_q)
                    `REG_INSTR: begin
                        instr_q <= (instr_q & ~wmask[23:0]) | wval[23:0];
                        state_q <= S_EXEC;
                        busy    <= 1'b1;
                    end
                    `REG_ACC:   if (w_strb_q[0]) acc_q   <= w_data_q[7:0];
                    `REG_FLAGS: if (w_strb_q[0]) flags_q <= w_data_q[7:0];
                    `REG_TPLO:  if (w_strb_q[0]) tplo_q  <= w_data_q[7:0];
                    `REG_TPHI:  if (w_strb_q[0]) tphi_q  <= w_data_q[7:0];
                    `REG_THIGH: if (w_strb_q[0]) thigh_q <= w_data_q[7:0];
                    `REG_PAGE:  if (w_strb_q[0]) page_q  <= w_data_q[PG_W-1:0];
                    `REG_MADDR: if (w_strb_q[0]) maddr_q <= w_data_q[DM_AW-1:0];
                    default: begin
                    end
                endcase
            end
            case (state_q)
                S_IDLE: begin
                end
                S_EXEC: begin
                    ill_q <= alu_ill;
                    if (alu_wr_acc) begin
                        acc_q <= alu_res;
                    end
                    if (alu_z_upd) begin
                        flags_q[`FLAG_Z] <= (alu_res == 8'h00);
                    end
                    if (alu_table) begin
                        // pointers are only read here, never stepped
                        pm_addr     <= tbl_addr;
                        pm_rd       <= 1'b1;
                        skip_seen_q <= 1'b0;
                        state_q     <= S_TWAIT;
                    end else if (alu_skip) begin
                        // the skipped fetch becomes a dummy cycle
                        skip_cycle  <= 1'b1;
                        skip_seen_q <= 1'b1;
                        cyc_q       <= `CYC_TWO;
                        state_q     <= S_DUMMY;
                    end else begin
                        skip_seen_q <= 1'b0;
                        cyc_q       <= `CYC_ONE;
                        busy        <= 1'b0;
                        state_q     <= S_IDLE;
                    end
                end
                S_DUMMY: begin
                    skip_cycle <= 1'b0;
                    busy       <= 1'b0;
                    state_q    <= S_IDLE;
                end
                S_TWAIT: begin
                    pm_rd   <= 1'b0;
                    state_q <= S_TCAP;
                end
                S_TCAP: begin
                    thigh_q <= pm_rdata[15:8];
                    cyc_q   <= `CYC_TWO;
                    busy    <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: begin
                    busy    <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== verif/prog_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------
// program memory
// ----------------
module prog_mem_model (
    input  wire logic        aclk,
    input  wire logic [15:0] pm_addr,
    input  wire logic        pm_rd,
    output wire logic [15:0] pm_rdata
);
    logic [15:0] a_q = 16'h0000;
    logic [1:0]  n_q = 2'h0;
    wire  [15:0] word = {a_q[15:8] ^ 8'h5A, a_q[7:0] ^ 8'hC3};
    always @(posedge aclk) begin
        if (pm_rd === 1'b1) begin
            a_q <= pm_addr;
            n_q <= 2'h3;
        end else if (n_q != 2'h0) begin
            n_q <= n_q - 2'h1;
        end
    end
    // inverted outside the valid span so a late capture cannot pass
    assign pm_rdata = (n_q != 2'h0) ? word : ~word;
endmodule
`default_nettype wire

// ==== verif/swap_skip_table_xor_unit_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------
// port checks
// ----------------
module swap_skip_table_xor_unit_sva #(
    parameter PM_AW = 16
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             ce,
    input wire logic [PM_AW-1:0] pm_addr,
    input wire logic             pm_rd,
    input wire logic             busy,
    input wire logic             skip_cycle
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_skip_one_pulse: assert property (skip_cycle && ce |=> !skip_cycle)
        else $error("skip cycle longer than one cycle");
    a_skip_then_idle: assert property (skip_cycle && ce |=> !busy)
        else $error("busy after the skip cycle");
    a_skip_after_exec: assert property ($rose(skip_cycle) |-> $past(busy) && busy)
        else $error("skip cycle without an executing instruction");
    a_exec_one_cycle: assert property ($rose(busy) && ce |=> !busy || skip_cycle || pm_rd)
        else $error("plain instruction not done in one cycle");
    a_table_pulse: assert property (pm_rd && ce |=> !pm_rd)
        else $error("table strobe longer than one cycle");
    a_table_busy: assert property (pm_rd |-> busy)
        else $error("table strobe while idle");
    a_table_length: assert property (pm_rd && ce ##1 ce ##1 ce |=> !busy)
        else $error("table read not finished in time");
    a_table_noskip: assert property (pm_rd |-> !skip_cycle [*4])
        else $error("table read took a skip");
    a_addr_held: assert property (!pm_rd |-> $stable(pm_addr))
        else $error("program address moved without a strobe");
    c_skip: cover property (skip_cycle);
    c_table: cover property (pm_rd);
    c_done: cover property ($fell(busy));
endmodule

bind swap_skip_table_xor_unit swap_skip_table_xor_unit_sva #(.PM_AW(PM_AW)) sva_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pm_addr(pm_addr),
    .pm_rd(pm_rd),
    .busy(busy),
    .skip_cycle(skip_cycle)
);
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defines.vh"
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, v;
    logic [1:0]  r;
    wire         awready, wready, bvalid, arready, rvalid, pm_rd, busy, skip_cycle;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] pm_addr, pm_rdata;
    int          n_fail = 0, n_compared = 0, cyc_n = 0, skips = 0, exp_skips = 0;
    logic [3:0]  sk_op [0:6] = '{`OP_SKZ, `OP_SKZ, `OP_SKZA, `OP_SKZA,
                                 `OP_SKZBIT, `OP_SKZBIT, `OP_SKZBIT};
    logic [7:0]  sk_v  [0:6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h7F, 8'h01, 8'hF7};
    logic [2:0]  sk_b  [0:6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h3};
    logic        sk_s  [0:6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    logic [3:0]  tr_op [0:2] = '{`OP_TRD_PAIR, `OP_TRD_CUR, `OP_TRD_LAST};
    logic [7:0]  tr_hi [0:2] = '{8'h12, 8'h56, 8'hFF};
    logic [3:0]  x_op  [0:5] = '{`OP_XORA, `OP_XORA, `OP_XOR_MEM, `OP_XOR_MEM, `OP_XORI, `OP_XORI};
    logic [7:0]  x_a   [0:5] = '{8'h5A, 8'h5A, 8'h33, 8'h33, 8'hF0, 8'hF0};
    logic [7:0]  x_m   [0:5] = '{8'h0F, 8'h5A, 8'h33, 8'h30, 8'h00, 8'h00};
    logic [7:0]  x_i   [0:5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h0F};
    logic [7:0]  x_r   [0:5] = '{8'h55, 8'h00, 8'h00, 8'h03, 8'h00, 8'hFF};

    swap_skip_table_xor_unit swap_skip_table_xor_unit_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_rdata(pm_rdata), .busy(busy), .skip_cycle(skip_cycle));
    prog_mem_model prog_mem_model_inst (
        .aclk(aclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));

    always #2.5 aclk = ~aclk;
    // ----------------
    // bus tasks
    // ----------------
    task summarize();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc_n <= cyc_n + 1;
        if (skip_cycle === 1'b1) skips <= skips + 1;
        if (cyc_n == 20000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'h0;
            if (wvalid && wready === 1'b1) wvalid <= 1'h0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'h0;
                b = 1'b1;
            end
        end
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask
    task rd(input logic [7:0] a);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!b) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'h0;
            if (rvalid === 1'b1) begin
                v = rdata;
                r = rresp;
                rready <= 1'h0;
                b = 1'b1;
            end
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(v, exp);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
    endtask
    // polling keeps the next request behind the running one
    task poll();
        v = 32'h0000_0001;
        while (v[`STAT_BUSY] !== 1'b0) rd(`REG_STAT);
    endtask
    task ex(input logic [3:0] op, input logic [2:0] bs, input logic [7:0] m, input logic [7:0] i);
        wr(`REG_INSTR, {8'h00, i, m, 1'b0, bs, op});
        poll();
    endtask
    task setm(input logic [7:0] a, input logic [7:0] d);
        wr(`REG_MADDR, {24'h0, a});
        wr(`REG_MDATA, {24'h0, d});
    endtask
    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rchk(8'(i * 4), 32'h0000_0000);
        setm(8'h10, 8'h3C);
        wr(`REG_FLAGS, 32'h0000_0003);
        ex(`OP_SWAP, 3'h0, 8'h10, 8'h00);
        rchk(`REG_MDATA, 32'h0000_00C3);
        rchk(`REG_STAT, 32'h0000_0010);
        setm(8'h10, 8'h5A);
        ex(`OP_SWAP_ACC, 3'h0, 8'h10, 8'h00);
        rchk(`REG_ACC, 32'h0000_00A5);
        rchk(`REG_MDATA, 32'h0000_005A);
        rchk(`REG_FLAGS, 32'h0000_0003);
        ex(4'hC, 3'h0, 8'h10, 8'h00);
        rchk(`REG_STAT, 32'h0000_0014);
        ex(`OP_NOP, 3'h0, 8'h10, 8'h00);
        rchk(`REG_STAT, 32'h0000_0010);
        rchk(`REG_ACC, 32'h0000_00A5);
        rchk(`REG_MDATA, 32'h0000_005A);
        for (int i = 0; i < 7; i++) begin
            setm(8'h20, sk_v[i]);
            wr(`REG_ACC, 32'h0000_0099);
            ex(sk_op[i], sk_b[i], 8'h20, 8'h00);
            exp_skips += sk_s[i];
            rchk(`REG_STAT, sk_s[i] ? 32'h0000_0022 : 32'h0000_0010);
            rchk(`REG_MDATA, {24'h0, sk_v[i]});
            rchk(`REG_ACC, (sk_op[i] == `OP_SKZA) ? {24'h0, sk_v[i]} : 32'h99);
        end
        rchk(`REG_FLAGS, 32'h0000_0003);
        chk(skips, exp_skips);
        wr(`REG_TPLO, 32'h0000_0034);
        wr(`REG_TPHI, 32'h0000_0012);
        wr(`REG_PAGE, 32'h0000_0056);
        for (int i = 0; i < 3; i++) begin
            wr(`REG_INSTR, {16'h0, 8'h30 + 8'(i), 4'h0, tr_op[i]});
            // a low clock enable must freeze the strobe and the busy state
            ce <= 1'b0;
            repeat (3) @(posedge aclk);
            chk({30'h0, busy, pm_rd}, 32'h0000_0003);
            ce <= 1'b1;
            poll();
            chk({16'h0, pm_addr}, {16'h0, tr_hi[i], 8'h34});
            wr(`REG_MADDR, 32'h30 + i);
            rchk(`REG_MDATA, 32'h0000_00F7);
            rchk(`REG_THIGH, {24'h0, tr_hi[i] ^ 8'h5A});
            rchk(`REG_STAT, 32'h0000_0020);
        end
        rchk(`REG_TPLO, 32'h0000_0034);
        rchk(`REG_TPHI, 32'h0000_0012);
        rchk(`REG_FLAGS, 32'h0000_0003);
        for (int i = 0; i < 6; i++) begin
            setm(8'h40, x_m[i]);
            wr(`REG_ACC, {24'h0, x_a[i]});
            ex(x_op[i], 3'h0, 8'h40, x_i[i]);
            rchk((x_op[i] == `OP_XOR_MEM) ? `REG_MDATA : `REG_ACC, {24'h0, x_r[i]});
            rchk(`REG_FLAGS, (x_r[i] == 8'h00) ? 32'h07 : 32'h03);
        end
        summarize();
    end
endmodule
`default_nettype wire
